/* hdl/rpb_loader_regs.vh */
// Constants for the reset, PLL ratio and boot image loader.
// Assumes a 20 MHz clock and word-aligned APB byte addresses.
`ifndef RPB_LOADER_REGS_VH
`define RPB_LOADER_REGS_VH

// APB register byte offsets
`define RPB_OFF_PLL        8'h00
`define RPB_OFF_STATUS     8'h04
`define RPB_OFF_LENGTH     8'h08
`define RPB_OFF_CRC        8'h0c
`define RPB_OFF_SECURITY   8'h10
`define RPB_OFF_IMGCRC     8'h14

// PLL register field positions
`define RPB_PLL_OD_LSB     0
`define RPB_PLL_F_LSB      8
`define RPB_PLL_R_LSB      24

// PLL settings per ratio pattern {bit1,bit0}
`define RPB_OD_DEFAULT     3'h1
`define RPB_R_DEFAULT      6'h00
`define RPB_F_RATIO40      12'h09f
`define RPB_F_RATIO16      12'h03f
`define RPB_F_RATIO8       12'h01f
`define RPB_F_RATIO4       12'h00f

// Boot source selection
`define RPB_SEC_BOOT_BIT   5
`define RPB_SEC_RESET      32'h00000000
`define RPB_OTP_BASE       32'h00000000
`define RPB_RAM_BASE       32'h00000000

// Checksum
`define RPB_CRC_POLY       32'hedb88320
`define RPB_CRC_PRESET     32'hffffffff
`define RPB_CRC_SKIP       32'h0d15ab1e

// Internal reset sequence timing
`define RPB_CLK_MHZ        20
`define RPB_SEQ_MIN_US     15

`endif

/* hdl/rpb_loader.v */
// Reset sequencer, PLL ratio decode and boot image loader for one tile.
// Assumes a byte source (flash or OTP reader) and a RAM byte port on mclk_i.
`include "rpb_loader_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module rpb_loader #(
  parameter integer SEQ_US  = `RPB_SEQ_MIN_US,  // Internal reset sequence length
  parameter integer CLK_MHZ = `RPB_CLK_MHZ      // Clock rate
) (
  input  wire        mclk_i,             // 20 MHz reference clock
  input  wire        nrst_i,             // Chip reset, active low
  input  wire        psel_i,             // APB select
  input  wire        penable_i,          // APB enable
  input  wire        pwrite_i,           // APB write
  input  wire [7:0]  paddr_i,            // APB byte address
  input  wire [31:0] pwdata_i,           // APB write data
  output reg  [31:0] prdata_o,           // APB read data
  output reg         pready_o,           // APB ready
  output reg         pslverr_o,          // APB error, unmapped address
  input  wire        ratio_select_bit0_i, // Ratio select pin 0
  input  wire        ratio_select_bit1_i, // Ratio select pin 1
  output reg         gpio_pulldown_o,    // Pull-down enable for all GPIO
  output reg  [2:0]  output_divider_o,   // PLL output divider
  output reg  [11:0] pll_feedback_o,     // PLL feedback value
  output reg  [5:0]  pll_refdiv_o,       // PLL reference divider
  output reg         sec_rd_o,           // Security word read request
  input  wire        sec_ack_i,          // Security word valid, one cycle
  input  wire [31:0] sec_word_i,         // Security word from OTP
  output reg         src_rd_o,           // Byte request to boot source
  output reg         src_otp_o,          // 1: OTP source, 0: flash
  output reg  [31:0] src_addr_o,         // Byte address in boot source
  input  wire        src_valid_i,        // Byte valid, one cycle
  input  wire [7:0]  src_data_i,         // Byte from boot source
  output reg         ram_we_o,           // RAM byte write strobe
  output reg  [31:0] ram_addr_o,         // RAM byte address
  output reg  [7:0]  ram_wdata_o,        // RAM byte data
  output reg         run_o,              // Start execution
  output reg  [31:0] run_addr_o,         // Start address
  output reg         boot_fail_o         // Checksum failure
);

  localparam integer SEQ_CYC = (SEQ_US * CLK_MHZ < 1) ? 1 : SEQ_US * CLK_MHZ;

  localparam [3:0] ST_SEQ  = 4'h0;
  localparam [3:0] ST_SEC  = 4'h1;
  localparam [3:0] ST_LEN  = 4'h2;
  localparam [3:0] ST_PROG = 4'h3;
  localparam [3:0] ST_CRC  = 4'h4;
  localparam [3:0] ST_CHK  = 4'h5;
  localparam [3:0] ST_RUN  = 4'h6;
  localparam [3:0] ST_FAIL = 4'h7;

  // One byte of the reflected CRC
  function [31:0] crc_byte;
    input [31:0] crc_in;
    input [7:0]  data;
    integer      i;
    reg   [31:0] c;
    begin
      c = crc_in ^ {24'h000000, data};
      for (i = 0; i < 8; i = i + 1) begin
        c = c[0] ? ((c >> 1) ^ `RPB_CRC_POLY) : (c >> 1);
      end
      crc_byte = c;
    end
  endfunction

  // Feedback value for a ratio pattern {bit1,bit0}
  function [11:0] ratio_f;
    input [1:0] sel;
    begin
      case (sel)
        2'b00:   ratio_f = `RPB_F_RATIO40;
        2'b11:   ratio_f = `RPB_F_RATIO16;
        2'b10:   ratio_f = `RPB_F_RATIO8;
        default: ratio_f = `RPB_F_RATIO4;
      endcase
    end
  endfunction

  reg  [2:0]  sync0;
  reg  [2:0]  sync1;
  reg  [1:0]  ratio_sel;
  reg  [3:0]  state;
  reg  [15:0] seq_cnt;
  reg  [31:0] sec_reg;
  reg  [31:0] shift;
  reg  [1:0]  byte_cnt;
  reg  [31:0] length;
  reg  [31:0] words_done;
  reg  [31:0] crc;
  reg  [31:0] img_crc;
  reg         pll_override;
  wire        apb_wr;
  wire        last_byte;
  wire [31:0] shifted;
  wire [31:0] crc_next;
  wire [31:0] status;

  assign apb_wr    = psel_i & penable_i & pready_o & pwrite_i;
  assign last_byte = src_valid_i & (byte_cnt == 2'h3);
  assign shifted   = {src_data_i, shift[31:8]};
  assign crc_next  = crc_byte(crc, src_data_i);
  assign status    = {16'h0000, 2'b00, ratio_sel, pll_override, src_otp_o,
                      boot_fail_o, run_o, 4'h0, state};

  // Ratio pins: three flops, value taken once stages two and three agree
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync0     <= 3'h0;
      sync1     <= 3'h0;
      ratio_sel <= 2'b00;
    end else begin
      sync0 <= {sync0[1:0], ratio_select_bit0_i};
      sync1 <= {sync1[1:0], ratio_select_bit1_i};
      if (sync0[2] == sync0[1]) begin
        ratio_sel[0] <= sync0[2];
      end
      if (sync1[2] == sync1[1]) begin
        ratio_sel[1] <= sync1[2];
      end
    end
  end

  // APB slave: one wait state, read data captured on the same edge that raises pready
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else if (psel_i & penable_i & ~pready_o) begin
      pready_o  <= 1'b1;
      pslverr_o <= 1'b0;
      case (paddr_i)
        `RPB_OFF_PLL:      prdata_o <= {2'b00, pll_refdiv_o, 4'h0, pll_feedback_o,
                                        5'h00, output_divider_o};
        `RPB_OFF_STATUS:   prdata_o <= status;
        `RPB_OFF_LENGTH:   prdata_o <= length;
        `RPB_OFF_CRC:      prdata_o <= ~crc;
        `RPB_OFF_SECURITY: prdata_o <= sec_reg;
        `RPB_OFF_IMGCRC:   prdata_o <= img_crc;
        default: begin
          prdata_o  <= 32'h00000000;
          pslverr_o <= 1'b1;
        end
      endcase
    end else begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // PLL settings: pin decode every cycle of the reset sequence, last value held, software override
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      output_divider_o <= `RPB_OD_DEFAULT;
      pll_feedback_o   <= `RPB_F_RATIO40;
      pll_refdiv_o     <= `RPB_R_DEFAULT;
      pll_override     <= 1'b0;
    end else if (apb_wr && paddr_i == `RPB_OFF_PLL) begin
      output_divider_o <= pwdata_i[`RPB_PLL_OD_LSB +: 3];
      pll_feedback_o   <= pwdata_i[`RPB_PLL_F_LSB +: 12];
      pll_refdiv_o     <= pwdata_i[`RPB_PLL_R_LSB +: 6];
      pll_override     <= 1'b1;
    end else if (state == ST_SEQ && !pll_override) begin
      // Tile clock formula set by these three fields
      output_divider_o <= `RPB_OD_DEFAULT;
      pll_feedback_o   <= ratio_f(ratio_sel);
      pll_refdiv_o     <= `RPB_R_DEFAULT;
    end
  end

  // Boot sequencer and image parser
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state           <= ST_SEQ;
      seq_cnt         <= 16'h0000;
      gpio_pulldown_o <= 1'b1;
      sec_rd_o        <= 1'b0;
      sec_reg         <= `RPB_SEC_RESET;
      src_rd_o        <= 1'b0;
      src_otp_o       <= 1'b0;
      src_addr_o      <= 32'h00000000;
      shift           <= 32'h00000000;
      byte_cnt        <= 2'h0;
      length          <= 32'h00000000;
      words_done      <= 32'h00000000;
      crc             <= `RPB_CRC_PRESET;
      img_crc         <= 32'h00000000;
      ram_we_o        <= 1'b0;
      ram_addr_o      <= `RPB_RAM_BASE;
      ram_wdata_o     <= 8'h00;
      run_o           <= 1'b0;
      run_addr_o      <= `RPB_RAM_BASE;
      boot_fail_o     <= 1'b0;
    end else begin
      ram_we_o <= 1'b0;
      case (state)
        ST_SEQ: begin
          if (seq_cnt == SEQ_CYC[15:0] - 16'h0001) begin
            gpio_pulldown_o <= 1'b0;
            sec_rd_o        <= 1'b1;
            state           <= ST_SEC;
          end else begin
            seq_cnt <= seq_cnt + 16'h0001;
          end
        end
        ST_SEC: begin
          // Security word loaded on the same edge as the source choice
          if (sec_ack_i) begin
            sec_rd_o  <= 1'b0;
            sec_reg   <= sec_word_i;
            src_otp_o <= sec_word_i[`RPB_SEC_BOOT_BIT];
            src_addr_o <= `RPB_OTP_BASE;
            src_rd_o   <= 1'b1;
            state      <= ST_LEN;
          end
        end
        ST_LEN: begin
          if (src_valid_i) begin
            shift      <= shifted;
            byte_cnt   <= byte_cnt + 2'h1;
            src_addr_o <= src_addr_o + 32'h00000001;
            crc        <= crc_next;
            if (last_byte) begin
              length <= shifted;
              state  <= (shifted == 32'h00000000) ? ST_CRC : ST_PROG;
            end
          end
        end
        ST_PROG: begin
          if (src_valid_i) begin
            byte_cnt    <= byte_cnt + 2'h1;
            src_addr_o  <= src_addr_o + 32'h00000001;
            crc         <= crc_next;
            // Bytes stored upward from RAM base
            ram_we_o    <= 1'b1;
            ram_wdata_o <= src_data_i;
            ram_addr_o  <= `RPB_RAM_BASE + {words_done[29:0], byte_cnt};
            if (last_byte) begin
              words_done <= words_done + 32'h00000001;
              if (words_done + 32'h00000001 == length) begin
                state <= ST_CRC;
              end
            end
          end
        end
        ST_CRC: begin
          if (src_valid_i) begin
            shift      <= shifted;
            byte_cnt   <= byte_cnt + 2'h1;
            src_addr_o <= src_addr_o + 32'h00000001;
            if (last_byte) begin
              src_rd_o <= 1'b0;
              img_crc  <= shifted;
              state    <= ST_CHK;
            end
          end
        end
        ST_CHK: begin
          if (img_crc == `RPB_CRC_SKIP || img_crc == ~crc) begin
            run_o      <= 1'b1;
            run_addr_o <= `RPB_RAM_BASE;
            state      <= ST_RUN;
          end else begin
            boot_fail_o <= 1'b1;
            state       <= ST_FAIL;
          end
        end
        ST_RUN: begin
          run_o <= 1'b1;
        end
        ST_FAIL: begin
          boot_fail_o <= 1'b1;
        end
        default: begin
          state <= ST_FAIL;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

/* testbench/rpb_loader_assertions.sv */
// Port checker for the boot loader block.
// Bound to rpb_loader; sees its ports only.
`include "rpb_loader_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module rpb_loader_chk #(
  parameter integer SEQ_US  = 15, // Sequence, us
  parameter integer CLK_MHZ = 20  // Clock, MHz
) (
  input wire logic        mclk_i,          // Clock
  input wire logic        nrst_i,          // Reset
  input wire logic        psel_i,          // Select
  input wire logic        penable_i,       // Enable
  input wire logic        pready_o,        // Ready
  input wire logic        gpio_pulldown_o, // Pull-down
  input wire logic        sec_rd_o,        // Sec request
  input wire logic        sec_ack_i,       // Sec answer
  input wire logic [31:0] sec_word_i,      // Sec word
  input wire logic        src_rd_o,        // Byte request
  input wire logic        src_otp_o,       // OTP source
  input wire logic        src_valid_i,     // Byte valid
  input wire logic [31:0] src_addr_o,      // Byte address
  input wire logic        ram_we_o,        // RAM write
  input wire logic [31:0] ram_addr_o,      // RAM address
  input wire logic        run_o,           // Started
  input wire logic [31:0] run_addr_o,      // Start address
  input wire logic        boot_fail_o      // Failed
);
  localparam int SEQ = SEQ_US * CLK_MHZ;
  logic [15:0] seq_cnt;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // Count edges while the pull-down stands
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) seq_cnt <= 16'h0;
    else if (gpio_pulldown_o) seq_cnt <= seq_cnt + 16'h1;
  end
  pd_reset_a: assert property (disable iff (1'h0) !nrst_i |-> gpio_pulldown_o)
    else $error("pull-down off in reset");
  seq_len_a: assert property ($fell(gpio_pulldown_o) |-> seq_cnt >= SEQ-1 && seq_cnt <= SEQ+1)
    else $error("reset sequence length wrong");
  sec_first_a: assert property ($rose(src_rd_o) |-> $past(sec_rd_o && sec_ack_i))
    else $error("boot read before security word");
  otp_sel_a: assert property ($rose(src_rd_o) |-> src_otp_o == $past(sec_word_i[5]))
    else $error("boot source wrong");
  src_base_a: assert property ($rose(src_rd_o) |-> src_addr_o == `RPB_OTP_BASE)
    else $error("image not from address 0");
  addr_step_a: assert property (src_rd_o && src_valid_i |=> src_addr_o == $past(src_addr_o) + 1)
    else $error("byte address did not step");
  ram_base_a: assert property (ram_we_o |-> ram_addr_o + 32'h5 == src_addr_o)
    else $error("program byte at wrong RAM address");
  run_addr_a: assert property (run_o |-> run_addr_o == `RPB_RAM_BASE && !boot_fail_o)
    else $error("start address wrong");
  end_a: assert property ($fell(src_rd_o) |=> run_o || boot_fail_o)
    else $error("no verdict after image");
  apb_wait_a: assert property (psel_i && $rose(penable_i) |=> pready_o ##1 !pready_o)
    else $error("register answer timing wrong");
  run_c: cover property ($rose(run_o));
  fail_c: cover property ($rose(boot_fail_o));
  otp_c: cover property ($rose(src_rd_o) && src_otp_o);
endmodule
bind rpb_loader rpb_loader_chk #(.SEQ_US(SEQ_US), .CLK_MHZ(CLK_MHZ)) rpb_loader_chk_inst (.*);
`default_nettype wire

/* testbench/rpb_boot_src.sv */
// Boot byte source and OTP security word model.
// Assumes level requests and one-cycle answer pulses.
`timescale 1ns/1ps
`default_nettype none
module rpb_boot_src (
  input  wire logic        mclk_i,      // Clock
  input  wire logic        nrst_i,      // Reset
  input  wire logic        slow_i,      // Stall bytes
  input  wire logic [31:0] boot_word_i, // Word to give
  input  wire logic        sec_rd_o,    // Sec request
  output var  logic        sec_ack_i,   // Sec answer
  output var  logic [31:0] sec_word_i,  // Sec word
  input  wire logic        src_rd_o,    // Byte request
  input  wire logic [31:0] src_addr_o,  // Byte address
  output var  logic        src_valid_i, // Byte valid
  output var  logic [7:0]  src_data_i   // Byte
);
  logic [7:0] img [0:63];
  logic [1:0] gap;
  // Answer requests; idle data changes every cycle
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sec_ack_i   <= 1'h0;
      sec_word_i  <= 32'h0;
      src_valid_i <= 1'h0;
      src_data_i  <= 8'h0;
      gap         <= 2'h0;
    end else begin
      sec_ack_i  <= sec_rd_o && !sec_ack_i;
      sec_word_i <= (sec_rd_o && !sec_ack_i) ? boot_word_i : ~sec_word_i;
      if (src_rd_o && !src_valid_i && gap == 2'h0) begin
        src_valid_i <= 1'h1;
        src_data_i  <= img[src_addr_o[5:0]];
        gap         <= slow_i ? 2'h3 : 2'h0;
      end else begin
        src_valid_i <= 1'h0;
        src_data_i  <= ~src_data_i;
        if (gap != 2'h0) gap <= gap - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the boot loader block.
// Assumes the byte source model and checker are compiled.
`include "rpb_loader_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        mclk_i = 1'h0, nrst_i = 1'h1, psel_i = 1'h0, penable_i = 1'h0;
  logic        pwrite_i = 1'h0, ratio_select_bit0_i = 1'h0, ratio_select_bit1_i = 1'h0;
  logic        slow_i = 1'h0;
  logic [7:0]  paddr_i = 8'h0;
  logic [31:0] pwdata_i = 32'h0, boot_word_i = 32'h0;
  logic        pready_o, pslverr_o, gpio_pulldown_o, sec_rd_o, sec_ack_i, src_rd_o;
  logic        src_otp_o, src_valid_i, ram_we_o, run_o, boot_fail_o;
  logic [2:0]  output_divider_o;
  logic [5:0]  pll_refdiv_o;
  logic [11:0] pll_feedback_o;
  logic [7:0]  src_data_i, ram_wdata_o, ram [0:63];
  logic [31:0] prdata_o, sec_word_i, src_addr_o, ram_addr_o, run_addr_o;
  int          num_errors = 0, comparisons = 0, cyc = 0;
  rpb_loader #(.SEQ_US(1)) rpb_loader_inst (.*);
  rpb_boot_src rpb_boot_src_inst (.*);
  // Clock, RAM capture and timeout
  initial forever #25 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    if (ram_we_o === 1'h1) ram[ram_addr_o[5:0]] <= ram_wdata_o;
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'h1;
    do @(posedge mclk_i); while (pready_o !== 1'h1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    // Idle edge so a following call never re-drives psel in this time step
    @(posedge mclk_i);
  endtask
  function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] b);
    int k;
    c = c ^ {24'h0, b};
    for (k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ `RPB_CRC_POLY : c >> 1;
    return c;
  endfunction
  // Build image (mode 0 good, 1 bad, 2 skip), reset, boot, judge
  task automatic boot(input logic [1:0] pins, input logic [31:0] sec, input int len,
                      input int mode);
    logic [31:0] c, w, r;
    logic e;
    int n;
    c = `RPB_CRC_PRESET;
    for (n = 0; n < 4; n++) begin
      rpb_boot_src_inst.img[n] = len[8*n +: 8];
      c = crc8(c, len[8*n +: 8]);
    end
    for (n = 0; n < 64; n++) ram[n] = 8'h0;
    for (n = 0; n < 4*len; n++) begin
      rpb_boot_src_inst.img[4+n] = 8'ha0 ^ n[7:0];
      c = crc8(c, 8'ha0 ^ n[7:0]);
    end
    w = (mode == 2) ? `RPB_CRC_SKIP : ~c ^ (mode == 1);
    for (n = 0; n < 4; n++) rpb_boot_src_inst.img[4+4*len+n] = w[8*n +: 8];
    {ratio_select_bit1_i, ratio_select_bit0_i} <= pins;
    boot_word_i <= sec;
    nrst_i <= 1'h0;
    // strap pins are board wiring, held static through this reset
    repeat (20) @(posedge mclk_i);
    chk(gpio_pulldown_o, 1'h1);
    nrst_i <= 1'h1;
    n = 0;
    while (run_o !== 1'h1 && boot_fail_o !== 1'h1 && n < 3000) begin
      @(posedge mclk_i);
      n++;
    end
    chk(n < 3000, 1'h1);
    chk(run_o, mode != 1);
    chk(boot_fail_o, mode == 1);
    chk(src_otp_o, sec[5]);
    chk(gpio_pulldown_o, 1'h0);
    for (n = 0; n < 4*len; n++) chk(ram[n], 8'ha0 ^ n[7:0]);
    apb(1'h0, `RPB_OFF_LENGTH, 32'h0, r, e);
    chk(r, len);
    apb(1'h0, `RPB_OFF_CRC, 32'h0, r, e);
    chk(r, ~c);
    apb(1'h0, `RPB_OFF_IMGCRC, 32'h0, r, e);
    chk(r, w);
  endtask
  task automatic t_ratio();
    logic [11:0] fb [0:3];
    int p;
    fb = '{12'h09f, 12'h00f, 12'h01f, 12'h03f};
    for (p = 0; p < 4; p++) begin
      boot(p[1:0], 32'h0, 0, 2);
      chk(pll_feedback_o, fb[p]);
      chk({output_divider_o, pll_refdiv_o}, 9'h040);
    end
    $display("test ratio done");
  endtask
  task automatic t_flash_crc();
    slow_i <= 1'h1;
    boot(2'h0, 32'hffffffdf, 3, 0);
    slow_i <= 1'h0;
    $display("test flash crc done");
  endtask
  task automatic t_bad_crc();
    boot(2'h1, 32'h0, 1, 1);
    $display("test bad crc done");
  endtask
  task automatic t_otp_skip();
    boot(2'h2, 32'h00000020, 2, 2);
    $display("test otp skip done");
  endtask
  task automatic t_pll_write();
    logic [31:0] r;
    logic e;
    boot(2'h3, 32'h0, 1, 0);
    apb(1'h1, `RPB_OFF_PLL, 32'h05012c02, r, e);
    @(posedge mclk_i);
    chk({pll_refdiv_o, pll_feedback_o, output_divider_o}, 21'h028962);
    apb(1'h0, `RPB_OFF_PLL, 32'h0, r, e);
    chk(r, 32'h05012c02);
    apb(1'h0, 8'h40, 32'h0, r, e);
    chk(e, 1'h1);
    $display("test pll write done");
  endtask
  initial begin
    nrst_i <= 1'h0;
    repeat (20) @(posedge mclk_i);
    t_ratio();
    t_flash_crc();
    t_bad_crc();
    t_otp_skip();
    t_pll_write();
    conclude();
  end
endmodule
`default_nettype wire
